// ---- verilog/ocm_map.vh ----
/*
  Timing and state constants of the overcurrent / undervoltage monitor.
  Assumes the monitor runs on a 50 MHz core clock.
*/
`ifndef OCM_MAP_VH
`define OCM_MAP_VH

// ==========================================================
// Clock rates
`define OCM_CORE_CLK_HZ      50000000
`define OCM_OSC_HZ           3500
// Divider from core clock to oscillator tick (rounded down)
`define OCM_OSC_DIV          (`OCM_CORE_CLK_HZ / `OCM_OSC_HZ)

// ==========================================================
// Delays in oscillator ticks (plain defaults, no figures given)
`define OCM_DLY1_TICKS       16'h0010
`define OCM_DLY2_TICKS       16'h0008
`define OCM_DLY3_TICKS       16'h0002
`define OCM_DLYUV_TICKS      16'h0040

// ==========================================================
// States
`define OCM_ST_NORMAL        2'h0
`define OCM_ST_OVERCUR       2'h1
`define OCM_ST_UVLO          2'h2

`endif

// ---- verilog/ocm_monitor.v ----
/*
  Overcurrent and undervoltage-lockout monitor: comparator qualification,
  state machine, discharge-gate drive and load-pin pulldown enable.
  Assumes comparator results are asynchronous levels and the gate pin is
  open-drain, resolved outside from the output enable.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ocm_map.vh"

// Operation
// - Stay normal while sense is at or below first threshold.
// - Normal: gate released for active-low, driven low for active-high.
// - Enter overcurrent only after level 1 or 3 persists for its delay, or on level 2 once level 1 has lasted the second-level delay.
// - Overcurrent: gate driven low for active-low, released for active-high.
// - Hold overcurrent while supply-to-load voltage is below release level.
// - Return to normal once release level is reached.
// - Enable load-pin pulldown during overcurrent.
// - Enter lockout after low battery lasts the lockout delay; assert gate.
// - Enable load-pin pulldown during lockout.
// - Leave lockout immediately when battery recovers.
// - All delays come from a counter dividing a 3.5 kHz tick.
// - Second-level delay starts when first threshold is detected.
// - Late second detection still trips within one second-level delay.
// - Three levels with own delays; third level optional.
module ocm_monitor #(
  parameter OSC_DIV  = `OCM_OSC_DIV,
  parameter DLY1     = `OCM_DLY1_TICKS,
  parameter DLY2     = `OCM_DLY2_TICKS,
  parameter DLY3     = `OCM_DLY3_TICKS,
  parameter DLYUV    = `OCM_DLYUV_TICKS
) (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        overLevel1,
  input  wire        overLevel2,
  input  wire        overLevel3,
  input  wire        releaseReached,
  input  wire        batteryLow,
  input  wire        activeHigh,
  input  wire        level3Enable,
  output wire        gateOut,
  output wire        gateOe_n,
  output reg         pulldownEn_ff,
  output reg  [1:0]  state_ff
);

  // ==========================================================
  // Input synchronisers
  // Straps bypass the synchronisers: they are fixed per variant and
  // only change while the block is held in reset
  reg [4:0] syncA_ff;
  reg [4:0] syncB_ff;
  wire      lvl1 = syncB_ff[0];
  wire      lvl2 = syncB_ff[1];
  wire      lvl3 = syncB_ff[2] & level3Enable;
  wire      relOk = syncB_ff[3];
  wire      batLow = syncB_ff[4];

  // Two stages; only the second is read
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_ff <= 5'h00;
      syncB_ff <= 5'h00;
    end else begin
      syncA_ff <= {batteryLow, releaseReached, overLevel3, overLevel2, overLevel1};
      syncB_ff <= syncA_ff;
    end
  end

  // ==========================================================
  // Oscillator tick divider
  reg [15:0] divCnt_ff;
  // Limitation: the divider rounds down, so ticks run slightly fast
  wire       tick = (divCnt_ff == OSC_DIV[15:0] - 16'h0001);

  // Divide core clock down to the 3.5 kHz timebase
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      divCnt_ff <= 16'h0000;
    else if (tick)
      divCnt_ff <= 16'h0000;
    else
      divCnt_ff <= divCnt_ff + 16'h0001;
  end

  // ==========================================================
  // Qualification counters
  reg [15:0] cnt1_ff;
  reg [15:0] cnt2_ff;
  reg [15:0] cnt3_ff;
  reg [15:0] cntUv_ff;
  reg        smp1_ff;
  reg        smp2_ff;
  reg        smp3_ff;
  reg        smpUv_ff;

  // Saturating count-up while condition holds
  function [15:0] ocm_count;
    input        cond;
    input [15:0] cnt;
    input [15:0] lim;
    begin
      if (!cond)
        ocm_count = 16'h0000;
      else if (cnt < lim)
        ocm_count = cnt + 16'h0001;
      else
        ocm_count = cnt;
    end
  endfunction

  wire inNormal = (state_ff == `OCM_ST_NORMAL);
  wire done1  = (cnt1_ff >= DLY1[15:0]);
  // Second delay timed from level-1 detection; trips once level 2 present
  wire done2  = smp2_ff & (cnt2_ff >= DLY2[15:0]);
  wire done3  = (cnt3_ff >= DLY3[15:0]);
  wire doneUv = (cntUv_ff >= DLYUV[15:0]);

  // Sample on tick, count on tick; a sampled drop clears the count on the next tick
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      smp1_ff  <= 1'b0;
      smp2_ff  <= 1'b0;
      smp3_ff  <= 1'b0;
      smpUv_ff <= 1'b0;
      cnt1_ff  <= 16'h0000;
      cnt2_ff  <= 16'h0000;
      cnt3_ff  <= 16'h0000;
      cntUv_ff <= 16'h0000;
    end else begin
      // Samples follow the tick whatever the state
      if (tick) begin
        smp1_ff  <= lvl1;
        smp2_ff  <= lvl2;
        smp3_ff  <= lvl3;
        smpUv_ff <= batLow;
      end
      // Leaving normal clears every timer at once, so a stale count
      // cannot re-trip the machine on the cycle it returns to normal
      if (!inNormal) begin
        cnt1_ff  <= 16'h0000;
        cnt2_ff  <= 16'h0000;
        cnt3_ff  <= 16'h0000;
        cntUv_ff <= 16'h0000;
      end else if (tick) begin
        cnt1_ff  <= ocm_count(smp1_ff, cnt1_ff, DLY1[15:0]);
        // Counts on level 1; late level 2 waits at most one more period
        if (cnt2_ff >= DLY2[15:0] && smp1_ff && !smp2_ff)
          cnt2_ff <= DLY2[15:0] - 16'h0001;
        else
          cnt2_ff <= ocm_count(smp1_ff, cnt2_ff, DLY2[15:0]);
        cnt3_ff  <= ocm_count(smp3_ff, cnt3_ff, DLY3[15:0]);
        cntUv_ff <= ocm_count(smpUv_ff, cntUv_ff, DLYUV[15:0]);
      end
    end
  end

  // ==========================================================
  // State machine
  reg [1:0] nxt_state;

  // Lockout takes precedence over a trip in normal: a collapsing supply makes detection unreliable
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      `OCM_ST_NORMAL: begin
        if (doneUv)
          nxt_state = `OCM_ST_UVLO;
        else if (done1 || done2 || done3)
          nxt_state = `OCM_ST_OVERCUR;
        else
          nxt_state = `OCM_ST_NORMAL;
      end
      `OCM_ST_OVERCUR: begin
        // Detection timers are held at zero here
        if (relOk)
          nxt_state = `OCM_ST_NORMAL;
        else
          nxt_state = `OCM_ST_OVERCUR;
      end
      `OCM_ST_UVLO: begin
        // No release delay: recovery acts as soon as it is synchronised
        if (!batLow)
          nxt_state = `OCM_ST_NORMAL;
        else
          nxt_state = `OCM_ST_UVLO;
      end
      default: nxt_state = `OCM_ST_NORMAL;
    endcase
  end

  // State and pulldown registers
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff      <= `OCM_ST_NORMAL;
      pulldownEn_ff <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      pulldownEn_ff <= (nxt_state != `OCM_ST_NORMAL);
    end
  end

  // ==========================================================
  // Gate drive: open drain, output always low, enable low drives
  reg tripped_ff;

  // Registered trip flag keeps the pin glitch free
  // Same decode as the pulldown, so pin and pulldown never disagree
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n)
      tripped_ff <= 1'b0;
    else
      tripped_ff <= (nxt_state != `OCM_ST_NORMAL);
  end

  assign gateOut  = 1'b0;
  // Active-low drives when tripped; active-high drives when normal
  assign gateOe_n = activeHigh ? tripped_ff : ~tripped_ff;

endmodule // ocm_monitor
`default_nettype wire

// ---- verification/ocm_monitor_properties.sv ----
/* Port checker of the monitor.
   Assumes a bind from the bench top. */
`timescale 1ns/100ps
`default_nettype none
module ocm_monitor_properties #(parameter OSC_DIV = 4, DLYUV = 8) (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       overLevel1,
  input wire logic       releaseReached,
  input wire logic       batteryLow,
  input wire logic       activeHigh,
  input wire logic       gateOut,
  input wire logic       gateOe_n,
  input wire logic       pulldownEn_ff,
  input wire logic [1:0] state_ff
);
  // ==========================================================
  // Raw run lengths, so an early trip is caught
  logic [15:0] hiCnt_ff;
  logic [15:0] lowCnt_ff;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hiCnt_ff <= '0;
      lowCnt_ff <= '0;
    end else begin
      hiCnt_ff <= overLevel1 ? hiCnt_ff + 16'h0001 : '0;
      lowCnt_ff <= batteryLow ? lowCnt_ff + 16'h0001 : '0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // Sync path is three edges deep
  sequence s_noRel; !releaseReached [*3]; endsequence
  sequence s_inOc; state_ff == 2'h1; endsequence
  property p_norm; state_ff == 2'h0 |-> gateOe_n == !activeHigh; endproperty
  a_norm: assert property (p_norm) else $error("gate in normal");
  property p_trip; state_ff != 2'h0 |-> gateOe_n == activeHigh && !gateOut; endproperty
  a_trip: assert property (p_trip) else $error("gate when tripped");
  property p_pd; state_ff != 2'h0 |-> pulldownEn_ff; endproperty
  a_pd: assert property (p_pd) else $error("pulldown off");
  property p_hold; s_noRel ##0 s_inOc |=> s_inOc; endproperty
  a_hold: assert property (p_hold) else $error("left overcurrent");
  property p_rel; $rose(releaseReached) ##0 s_inOc |-> ##[1:4] state_ff == 2'h0; endproperty
  a_rel: assert property (p_rel) else $error("no release");
  property p_uvx; $fell(batteryLow) && state_ff == 2'h2 |-> ##[1:4] state_ff == 2'h0; endproperty
  a_uvx: assert property (p_uvx) else $error("lockout kept");
  property p_oc; $rose(state_ff == 2'h1) |-> hiCnt_ff >= OSC_DIV; endproperty
  a_oc: assert property (p_oc) else $error("early trip");
  property p_uv; $rose(state_ff == 2'h2) |-> lowCnt_ff >= (DLYUV - 1) * OSC_DIV; endproperty
  a_uv: assert property (p_uv) else $error("early lockout");
endmodule // ocm_monitor_properties
`default_nettype wire

// ---- verification/ocm_far_model.sv ----
/* Far side: nested comparators and the discharge switch.
   Assumes the bench sets a sense code. */
`timescale 1ns/100ps
`default_nettype none
module ocm_far_model (
  input  wire logic [1:0] senseLvl,
  input  wire logic       gateOut,
  input  wire logic       gateOe_n,
  input  wire logic       activeHigh,
  output var  logic [2:0] overLvl,
  output var  logic       fetOn
);
  // ==========================================================
  // A higher threshold implies the lower ones; test pin left open
  always_comb overLvl = {senseLvl > 2'h2, senseLvl > 2'h1, senseLvl > 2'h0};
  // Released pin is pulled high outside
  always_comb fetOn = (gateOe_n ? 1'b1 : gateOut) ^ activeHigh;
endmodule // ocm_far_model
`default_nettype wire

// ---- verification/tb_top.sv ----
/* Bench top: drives comparator levels, judges state, gate and pulldown.
   Assumes shrunken delays to keep the run short. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  // ==========================================================
  // Stimulus and design
  localparam int OD = 4, D1 = 32, D2 = 8, D3 = 2, DU = 8;
  logic       core_clk = 1'b0, arst_n = 1'b0, releaseReached = 1'b0, batteryLow = 1'b0;
  logic       activeHigh = 1'b0, level3Enable = 1'b1, gateOut, gateOe_n, pulldownEn_ff, fetOn;
  logic [1:0] senseLvl = 2'h0, state_ff;
  logic [2:0] overLvl;
  int         errors = 0, n_checks = 0;
  always #10 core_clk = ~core_clk;
  ocm_far_model i_far (.senseLvl(senseLvl), .gateOut(gateOut), .gateOe_n(gateOe_n),
    .activeHigh(activeHigh), .overLvl(overLvl), .fetOn(fetOn));
  ocm_monitor #(.OSC_DIV(OD), .DLY1(D1), .DLY2(D2), .DLY3(D3), .DLYUV(DU)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .overLevel1(overLvl[0]), .overLevel2(overLvl[1]),
    .overLevel3(overLvl[2]), .releaseReached(releaseReached), .batteryLow(batteryLow),
    .activeHigh(activeHigh), .level3Enable(level3Enable), .gateOut(gateOut),
    .gateOe_n(gateOe_n), .pulldownEn_ff(pulldownEn_ff), .state_ff(state_ff));
  task automatic chk(input logic [15:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Straps only change under reset
  task automatic rst(input logic ah, l3);
    @(negedge core_clk);
    {arst_n, senseLvl, releaseReached, batteryLow, activeHigh, level3Enable} = {3'h0, 2'h0, ah, l3};
    repeat (4) @(negedge core_clk);
    arst_n = 1'b1;
  endtask
  task automatic waitSt(input logic [1:0] st, input int lim, output int n);
    n = 0;
    while (state_ff !== st && n < lim) begin
      @(negedge core_clk);
      n++;
    end
  endtask
  // Trip window in cycles, optional early first level, then hold and release
  task automatic tLvl(input logic [1:0] lvl, input logic ah, l3, input int pre, lo, hi);
    int n;
    rst(ah, l3);
    if (pre > 0) begin
      senseLvl = 2'h1;
      repeat (pre) @(negedge core_clk);
    end
    senseLvl = lvl;
    waitSt(2'h1, 200, n);
    chk(n >= lo && n <= hi, 1'b1);
    chk({fetOn, pulldownEn_ff}, 2'h1);
    senseLvl = 2'h0;
    repeat (20) @(negedge core_clk);
    chk(state_ff, 2'h1);
    releaseReached = 1'b1;
    repeat (4) @(negedge core_clk);
    chk({state_ff, fetOn}, 3'h1);
    $display("level test %0d done", lvl);
  endtask
  // Two bursts, each shorter than the level-1 delay, must not add up
  task automatic tDrop;
    rst(1'b0, 1'b1);
    repeat (2) begin
      senseLvl = 2'h1;
      repeat ((D1 - 12) * OD) @(negedge core_clk);
      senseLvl = 2'h0;
      repeat (4 * OD) @(negedge core_clk);
    end
    chk({state_ff, pulldownEn_ff, fetOn}, 4'h1);
    $display("drop test done");
  endtask
  task automatic tUv(input logic ah);
    int n;
    rst(ah, 1'b1);
    repeat (100) @(negedge core_clk);
    chk(state_ff, 2'h0);
    batteryLow = 1'b1;
    waitSt(2'h2, 100, n);
    chk(n >= (DU - 1) * OD && n <= (DU + 1) * OD + 4, 1'b1);
    chk({fetOn, pulldownEn_ff}, 2'h1);
    batteryLow = 1'b0;
    repeat (4) @(negedge core_clk);
    chk(state_ff, 2'h0);
    $display("lockout test done");
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Watchdog well beyond the fewer than one thousand cycles the tests need
  initial begin
    #200000;
    errors++;
    conclude();
  end
  initial begin
    tLvl(2'h1, 1'b0, 1'b1, 0, (D1 - 1) * OD, (D1 + 1) * OD + 4);
    tLvl(2'h2, 1'b1, 1'b1, 0, (D2 - 1) * OD, (D2 + 1) * OD + 4);
    tLvl(2'h3, 1'b0, 1'b1, 0, (D3 - 1) * OD, (D3 + 1) * OD + 4);
    tLvl(2'h3, 1'b1, 1'b0, 0, (D2 - 1) * OD, (D2 + 1) * OD + 4);
    tLvl(2'h2, 1'b0, 1'b1, (D2 + 2) * OD, 0, D2 * OD + 4);
    tDrop();
    tUv(1'b0);
    tUv(1'b1);
    conclude();
  end
endmodule // tb_top
bind ocm_monitor ocm_monitor_properties #(.OSC_DIV(OSC_DIV), .DLYUV(DLYUV)) i_prop (
  .core_clk(core_clk), .arst_n(arst_n), .overLevel1(overLevel1), .releaseReached(releaseReached),
  .batteryLow(batteryLow), .activeHigh(activeHigh), .gateOut(gateOut), .gateOe_n(gateOe_n),
  .pulldownEn_ff(pulldownEn_ff), .state_ff(state_ff));
`default_nettype wire
